/* hdlcs_pkg.sv */
// Package for the receive link message count and status block
package hdlcs_pkg;
	localparam int unsigned ADDR_W       = 12;
	localparam int unsigned CNT_W        = 7;
	localparam logic [11:0] OFF_MSG_CNT  = 12'h0145;
	localparam logic [11:0] OFF_CTRL     = 12'h014C;
	localparam logic [11:0] OFF_STATUS   = 12'h014D;
	localparam logic [11:0] OFF_MASK     = 12'h014E;
	localparam int unsigned PTR_BIT      = 7;
	localparam int unsigned CTRL_MOS_BIT = 0;
	localparam int unsigned ST_EOT_BIT   = 0;
	localparam int unsigned ST_MSG_BIT   = 1;
	localparam logic [6:0]  CNT_RST      = 7'h00;
	localparam logic [6:0]  CNT_MAX      = 7'h7F;
	localparam logic [7:0]  REG_RST      = 8'h00;

	// Events from the receive HDLC engine, same clock
	typedef struct packed {
		logic byte_vld;    // One received byte stored, FCS bytes included
		logic frame_end;   // Good message complete in the write buffer
		logic frame_abort; // Message dropped
	} hdlcs_rx_t;

	// Register port
	typedef struct packed {
		logic [11:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} hdlcs_bus_t;
endpackage

/* hdlcs_len_cnt.sv */
// Saturating byte counter for one received message
`timescale 1ns/1ps
module hdlcs_len_cnt #(
	parameter int unsigned CNT_W = 7
) (
	input  wire logic             core_clk,  // System clock
	input  wire logic             rst,       // Async reset, high
	input  wire logic             byte_vld,  // Byte received
	input  wire logic             clear,     // Message finished or dropped
	output logic      [CNT_W-1:0] count      // Bytes so far
);
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;

	always_comb begin
		nxt_cnt = cnt_ff;
		if (clear) begin
			nxt_cnt = '0;
		end else if (byte_vld && cnt_ff != {CNT_W{1'b1}}) begin
			nxt_cnt = cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	assign count = cnt_ff;
endmodule

/* hdlcs_rx_msg_status.sv */
// Receive link message count, buffer pointer and end-of-transfer status
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module hdlcs_rx_msg_status (
	input  wire logic                 core_clk,   // System clock, 50 MHz
	input  wire logic                 rst,        // Async reset, high
	input  wire hdlcs_pkg::hdlcs_bus_t bus,       // Register port request
	output logic                [7:0] rdata,      // Read data, cycle after rd
	input  wire hdlcs_pkg::hdlcs_rx_t rx,         // Receive engine events
	output logic                      wr_buf_sel, // Buffer the engine fills next
	output logic                      irq         // Level interrupt
);
	localparam int unsigned CW = hdlcs_pkg::CNT_W;

	logic          newest_buffer_pointer_ff;
	logic          nxt_newest_buffer_pointer;
	logic [CW-1:0] len_ff;
	logic [CW-1:0] nxt_len;
	logic [CW-1:0] thresh_ff;
	logic [CW-1:0] nxt_thresh;
	logic [CW-1:0] rep_ff;
	logic [CW-1:0] nxt_rep;
	logic          done_ff;
	logic          nxt_done;
	logic          mos_ff;
	logic          nxt_mos;
	logic [1:0]    status_ff;
	logic [1:0]    nxt_status;
	logic [1:0]    mask_ff;
	logic [1:0]    nxt_mask;
	logic [7:0]    rdata_ff;
	logic [7:0]    nxt_rdata;
	logic [CW-1:0] frame_len;
	logic [CW-1:0] rx_message_length_or_repeats;
	logic          store;
	logic          eot_evt;
	logic          wr_cnt;
	logic          rd_status;

	hdlcs_len_cnt #(
		.CNT_W(CW)
	) u_len (
		.core_clk(core_clk),
		.rst     (rst),
		.byte_vld(rx.byte_vld),
		.clear   (rx.frame_end | rx.frame_abort),
		.count   (frame_len)
	);

	assign store     = rx.frame_end & ~rx.frame_abort;
	assign wr_cnt    = bus.wr && bus.addr == hdlcs_pkg::OFF_MSG_CNT;
	assign rd_status = bus.rd && bus.addr == hdlcs_pkg::OFF_STATUS;
	// Zero threshold means endless reception with no end-of-transfer
	assign eot_evt   = store && !mos_ff && !done_ff && thresh_ff != hdlcs_pkg::CNT_RST
		&& rep_ff + 1'b1 == thresh_ff;

	// Message bookkeeping
	always_comb begin
		nxt_newest_buffer_pointer = newest_buffer_pointer_ff;
		nxt_len    = len_ff;
		nxt_rep    = rep_ff;
		nxt_done   = done_ff;
		nxt_thresh = thresh_ff;
		if (store) begin
			// Pointer moves on every stored message; the length moves with it in the same cycle only when mos_ff is set
			nxt_newest_buffer_pointer = ~newest_buffer_pointer_ff;
			if (mos_ff) begin
				nxt_len = frame_len;
			end else if (eot_evt) begin
				nxt_rep  = hdlcs_pkg::CNT_RST;
				nxt_done = 1'b1;
			end else if (!done_ff && rep_ff != hdlcs_pkg::CNT_MAX) begin
				nxt_rep = rep_ff + 1'b1;
			end
		end
		// A write rearms the repetition count; the pointer is not writable
		if (wr_cnt) begin
			nxt_thresh = bus.wdata[CW-1:0];
			nxt_rep    = hdlcs_pkg::CNT_RST;
			nxt_done   = 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			newest_buffer_pointer_ff <= 1'b0;
			len_ff                   <= hdlcs_pkg::CNT_RST;
			rep_ff                   <= hdlcs_pkg::CNT_RST;
			done_ff                  <= 1'b0;
			thresh_ff                <= hdlcs_pkg::CNT_RST;
		end else begin
			newest_buffer_pointer_ff <= nxt_newest_buffer_pointer;
			len_ff                   <= nxt_len;
			rep_ff                   <= nxt_rep;
			done_ff                  <= nxt_done;
			thresh_ff                <= nxt_thresh;
		end
	end

	assign rx_message_length_or_repeats = mos_ff ? len_ff : thresh_ff;

	// Registers, interrupt status and read data
	always_comb begin
		nxt_mos    = mos_ff;
		nxt_mask   = mask_ff;
		nxt_status = status_ff;
		nxt_rdata  = hdlcs_pkg::REG_RST;
		if (bus.wr && bus.addr == hdlcs_pkg::OFF_CTRL) begin
			nxt_mos = bus.wdata[hdlcs_pkg::CTRL_MOS_BIT];
		end
		if (bus.wr && bus.addr == hdlcs_pkg::OFF_MASK) begin
			nxt_mask = bus.wdata[1:0];
		end
		if (rd_status) begin
			nxt_status = 2'b00;
		end
		// Set wins over the read clear
		if (eot_evt) begin
			nxt_status[hdlcs_pkg::ST_EOT_BIT] = 1'b1;
		end
		if (store && mos_ff) begin
			nxt_status[hdlcs_pkg::ST_MSG_BIT] = 1'b1;
		end
		if (bus.rd) begin
			case (bus.addr)
				hdlcs_pkg::OFF_MSG_CNT: begin
					nxt_rdata = {newest_buffer_pointer_ff, rx_message_length_or_repeats};
				end
				hdlcs_pkg::OFF_CTRL: begin
					nxt_rdata = {7'h00, mos_ff};
				end
				hdlcs_pkg::OFF_STATUS: begin
					nxt_rdata = {6'h00, status_ff};
				end
				hdlcs_pkg::OFF_MASK: begin
					nxt_rdata = {6'h00, mask_ff};
				end
				default: begin
					nxt_rdata = hdlcs_pkg::REG_RST;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mos_ff    <= 1'b0;
			mask_ff   <= 2'b00;
			status_ff <= 2'b00;
			rdata_ff  <= hdlcs_pkg::REG_RST;
		end else begin
			mos_ff    <= nxt_mos;
			mask_ff   <= nxt_mask;
			status_ff <= nxt_status;
			rdata_ff  <= nxt_rdata;
		end
	end

	assign rdata      = rdata_ff;
	assign irq        = |(status_ff & mask_ff);
	assign wr_buf_sel = ~newest_buffer_pointer_ff;

	property p_ptr_flip;
		@(posedge core_clk) disable iff (rst)
		store |=> newest_buffer_pointer_ff != $past(newest_buffer_pointer_ff) && wr_buf_sel == $past(newest_buffer_pointer_ff);
	endproperty
	a_ptr_flip: assert property (p_ptr_flip) else $error("Buffer pointer did not flip on stored message");

	property p_eot_count;
		@(posedge core_clk) disable iff (rst)
		eot_evt |=> status_ff[hdlcs_pkg::ST_EOT_BIT] && rep_ff == 7'h00 && $past(rep_ff) == $past(thresh_ff) - 7'h01;
	endproperty
	a_eot_count: assert property (p_eot_count) else $error("End of transfer at wrong repetition");

	property p_no_eot_zero;
		@(posedge core_clk) disable iff (rst)
		(thresh_ff == 7'h00 && !mos_ff && !rd_status) |=> !$rose(status_ff[hdlcs_pkg::ST_EOT_BIT]);
	endproperty
	a_no_eot_zero: assert property (p_no_eot_zero) else $error("End of transfer raised with zero count");

	property p_mos_len;
		@(posedge core_clk) disable iff (rst)
		(store && mos_ff) |=> len_ff == $past(frame_len) && status_ff[hdlcs_pkg::ST_MSG_BIT];
	endproperty
	a_mos_len: assert property (p_mos_len) else $error("Stored length differs from received count");

	property p_len_counts_all;
		@(posedge core_clk) disable iff (rst)
		(rx.byte_vld && !rx.frame_end && !rx.frame_abort && frame_len != 7'h7F) |=> frame_len == $past(frame_len) + 7'h01;
	endproperty
	a_len_counts_all: assert property (p_len_counts_all) else $error("Received byte not counted");

	property p_together;
		@(posedge core_clk) disable iff (rst)
		($changed(len_ff) || $changed(newest_buffer_pointer_ff)) |-> $past(store);
	endproperty
	a_together: assert property (p_together) else $error("Pointer or length moved without a stored message");

	property p_rdata_one_cycle;
		@(posedge core_clk) disable iff (rst)
		!bus.rd |=> rdata == 8'h00;
	endproperty
	a_rdata_one_cycle: assert property (p_rdata_one_cycle) else $error("Read data outside the read answer cycle");

	property p_eot_halt;
		@(posedge core_clk) disable iff (rst)
		(done_ff && !wr_cnt) |=> rep_ff == $past(rep_ff) && !$rose(status_ff[hdlcs_pkg::ST_EOT_BIT]);
	endproperty
	a_eot_halt: assert property (p_eot_halt) else $error("Repetitions counted after end of transfer");

	property p_rearm;
		@(posedge core_clk) disable iff (rst)
		wr_cnt |=> thresh_ff == $past(bus.wdata[CW-1:0]) && rep_ff == 7'h00 && !done_ff;
	endproperty
	a_rearm: assert property (p_rearm) else $error("Count write did not rearm the repetition count");

	property p_status_clear;
		@(posedge core_clk) disable iff (rst)
		(rd_status && !eot_evt && !(store && mos_ff)) |=> status_ff == 2'b00;
	endproperty
	a_status_clear: assert property (p_status_clear) else $error("Status read did not clear the status bits");
endmodule

/* hdlcs_far_end.sv */
// Remote terminal model sending link messages as receive engine events
`timescale 1ns/1ps
module hdlcs_far_end (
	input  wire logic           core_clk, // System clock
	input  wire logic           go,       // Send one message
	input  wire logic     [7:0] nbytes,   // Bytes in the message
	input  wire logic           drop,     // End with abort, not store
	input  wire logic           slow,     // Idle cycle after each byte
	output hdlcs_pkg::hdlcs_rx_t rx,      // Engine events
	output logic                busy      // Message in flight
);
	initial begin
		rx = '0;
		busy = 1'b0;
	end
	always begin
		@(posedge core_clk);
		if (go) begin
			busy <= 1'b1;
			repeat (nbytes) begin
				rx <= 3'b100;
				@(posedge core_clk);
				if (slow) begin
					rx <= '0;
					@(posedge core_clk);
				end
			end
			rx <= drop ? 3'b001 : 3'b010;
			@(posedge core_clk);
			rx <= '0;
			busy <= 1'b0;
		end
	end
endmodule

/* tb.sv */
// Testbench for the receive message count and status block
`timescale 1ns/1ps
module tb;
	logic                  core_clk;
	logic                  rst;
	hdlcs_pkg::hdlcs_bus_t b;
	logic            [7:0] rdata;
	hdlcs_pkg::hdlcs_rx_t  rx;
	logic                  wr_buf_sel;
	logic                  irq;
	logic                  go;
	logic            [7:0] nb;
	logic                  drop;
	logic                  slow;
	logic                  busy;
	logic                  ptr;
	int                    errors;
	int                    checked;
	logic            [7:0] len_row[4] = '{8'h01, 8'h05, 8'h7F, 8'h82};
	logic            [6:0] exp_row[4] = '{7'h01, 7'h05, 7'h7F, 7'h7F};
	hdlcs_rx_msg_status hdlcs_rx_msg_status_i (.core_clk(core_clk), .rst(rst), .bus(b), .rdata(rdata),
		.rx(rx), .wr_buf_sel(wr_buf_sel), .irq(irq));
	hdlcs_far_end hdlcs_far_end_i (.core_clk(core_clk), .go(go), .nbytes(nb), .drop(drop), .slow(slow),
		.rx(rx), .busy(busy));
	task automatic test_done;
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		b.addr <= a;
		b.wdata <= d;
		b.wr <= 1'b1;
		@(posedge core_clk);
		b.wr <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
		b.addr <= a;
		b.rd <= 1'b1;
		@(posedge core_clk);
		b.rd <= 1'b0;
		#1 chk("rdata", rdata & m, e);
		@(posedge core_clk);
	endtask
	task automatic send(input logic [7:0] n, input logic d);
		int k;
		nb <= n;
		drop <= d;
		go <= 1'b1;
		@(posedge core_clk);
		go <= 1'b0;
		@(posedge core_clk);
		for (k = 0; k < 600 && busy; k++)
			@(posedge core_clk);
		if (busy)
			errors++;
		if (!d)
			ptr = ~ptr;
		@(posedge core_clk);
	endtask
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	initial begin
		#100us;
		errors++;
		test_done();
	end
	initial begin
		errors = 0;
		checked = 0;
		b = '0;
		go = 1'b0;
		nb = 8'h00;
		drop = 1'b0;
		slow = 1'b0;
		ptr = 1'b0;
		rst = 1'b1;
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		chk("sel", {7'h00, wr_buf_sel}, 8'h01);
		rd(hdlcs_pkg::OFF_MSG_CNT, 8'hFF, 8'h00);
		wr(hdlcs_pkg::OFF_CTRL, 8'h01);
		wr(hdlcs_pkg::OFF_MASK, 8'h02);
		for (int i = 0; i < 4; i++) begin
			slow <= i[0];
			send(len_row[i], 1'b0);
			chk("irq", {7'h00, irq}, 8'h01);
			rd(hdlcs_pkg::OFF_STATUS, 8'hFF, 8'h02);
			chk("irq", {7'h00, irq}, 8'h00);
			rd(hdlcs_pkg::OFF_MSG_CNT, 8'hFF, {ptr, exp_row[i]});
			chk("sel", {7'h00, wr_buf_sel}, {7'h00, ~ptr});
		end
		// Dropped message leaves pointer and length alone
		send(8'h04, 1'b1);
		rd(hdlcs_pkg::OFF_MSG_CNT, 8'hFF, {ptr, 7'h7F});
		rd(hdlcs_pkg::OFF_STATUS, 8'hFF, 8'h00);
		wr(12'h146, 8'hFF);
		rd(12'h146, 8'hFF, 8'h00);
		wr(hdlcs_pkg::OFF_CTRL, 8'h00);
		wr(hdlcs_pkg::OFF_MSG_CNT, 8'h83);
		wr(hdlcs_pkg::OFF_MASK, 8'h01);
		repeat (2) send(8'h02, 1'b0);
		chk("irq", {7'h00, irq}, 8'h00);
		send(8'h02, 1'b0);
		chk("irq", {7'h00, irq}, 8'h01);
		rd(hdlcs_pkg::OFF_STATUS, 8'h01, 8'h01);
		rd(hdlcs_pkg::OFF_MSG_CNT, 8'hFF, {ptr, 7'h03});
		send(8'h02, 1'b0);
		rd(hdlcs_pkg::OFF_STATUS, 8'h01, 8'h00);
		wr(hdlcs_pkg::OFF_MSG_CNT, 8'h00);
		repeat (3) send(8'h02, 1'b0);
		chk("irq", {7'h00, irq}, 8'h00);
		rd(hdlcs_pkg::OFF_STATUS, 8'h01, 8'h00);
		// Status read two cycles before a slow message is stored: the new bit is set afterwards
		wr(hdlcs_pkg::OFF_CTRL, 8'h01);
		fork
			send(8'h02, 1'b0);
			begin
				repeat (3) @(posedge core_clk);
				rd(hdlcs_pkg::OFF_STATUS, 8'hFF, 8'h00);
			end
		join
		rd(hdlcs_pkg::OFF_STATUS, 8'hFF, 8'h02);
		rd(hdlcs_pkg::OFF_MSG_CNT, 8'hFF, {ptr, 7'h02});
		wr(hdlcs_pkg::OFF_MASK, 8'h02);
		send(8'h03, 1'b0);
		chk("irq", {7'h00, irq}, 8'h01);
		// Reset in mid-run clears pointer, length, status and read data
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		chk("irq", {7'h00, irq}, 8'h00);
		chk("sel", {7'h00, wr_buf_sel}, 8'h01);
		chk("rdata", rdata, 8'h00);
		rst <= 1'b0;
		ptr = 1'b0;
		@(posedge core_clk);
		rd(hdlcs_pkg::OFF_MSG_CNT, 8'hFF, 8'h00);
		rd(hdlcs_pkg::OFF_STATUS, 8'hFF, 8'h00);
		test_done();
	end
endmodule
